// *** src/dma_channel_defs.svh ***
`ifndef DMA_CHANNEL_DEFS_SVH
`define DMA_CHANNEL_DEFS_SVH

`define REG_ADDR_W 5
`define OFF_SOURCE 4'h0
`define OFF_DEST 4'h4
`define OFF_COUNT 4'h8
`define OFF_CONTROL 4'hC
`define CH_SEL_BIT 4

`define CTL_WIDTH 16
`define CNT_WIDTH 24
`define CTL_RESET 16'h0000

`define DEST_STEP_HI 15
`define DEST_STEP_LO 14
`define SRC_STEP_HI 13
`define SRC_STEP_LO 12
`define UNIT_SIZE_HI 11
`define UNIT_SIZE_LO 10
`define ACK_PHASE_BIT 8
`define ACK_POLARITY_BIT 7
`define SINGLE_ADDR_BIT 3
`define TRANSFER_END_BIT 1
`define CHANNEL_ENABLE_BIT 0

`define STEP_FIXED 2'h0
`define STEP_INC 2'h1
`define STEP_DEC 2'h2

`define SIZE_BYTE 2'h0
`define SIZE_WORD 2'h1
`define SIZE_LONG 2'h2
`define SIZE_16B 2'h3

`define BYTES_BYTE 32'h0000_0001
`define BYTES_WORD 32'h0000_0002
`define BYTES_LONG 32'h0000_0004
`define BYTES_16B 32'h0000_0010

`define CNT_STEP_UNIT 24'h00_0001
`define CNT_STEP_16B 24'h00_0004
`define CNT_ZERO 24'h00_0000
`define LAST_BEAT 2'h3

`endif

// *** src/dma_channel_pkg.sv ***
package dma_channel_pkg;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_RD = 3'b010,
		ST_WR = 3'b100
	} fsm_e;

	typedef struct packed {
		logic [1:0][31:0] src;
		logic [1:0][31:0] dst;
		logic [1:0][23:0] cnt;
		logic [1:0][15:0] ctl;
		fsm_e fsm;
		logic ch;
		logic [1:0] beat;
		logic [3:0][31:0] hold;
		logic req;
		logic we;
		logic [31:0] addr;
		logic [1:0] size;
		logic [31:0] wdata;
		logic [1:0] ack_act;
		logic [1:0] ack_pin;
		logic [31:0] rdata;
	} dma_state_s;

endpackage

// *** src/dma_channel_address_count_mode.sv ***
`timescale 1ns/10ps
`include "dma_channel_defs.svh"

// Function
// - Source pointer: 32-bit, shows next source address
// - Device-to-memory single mode ignores source pointer
// - Pointers undefined at reset, kept in standby
// - Destination pointer: 32-bit, shows next destination
// - Memory-to-device single mode ignores destination pointer
// - Count uses low 24 bits; upper read zero
// - Count one is one; zero means 16777216
// - Count read returns remaining transfers
// - Count undefined at reset, kept in standby
// - Control low 16 bits; zeroed by reset, standby
// - Transfer end flag cleared only by writing zero, reset or standby
// - Destination step: fixed, increment, decrement by size
// - Destination step ignored toward acknowledged device
// - Source step: fixed, increment, decrement by size
// - 16-byte unit: source always advances sixteen
// - Source step ignored from acknowledged device
// - Unit size byte, word, long, sixteen bytes
// - Count reaching zero ends transfer, sets flag
// - Bit three selects dual or single address
module dma_channel_address_count_mode
	import dma_channel_pkg::*;
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic standby,
	input wire logic module_stop,
	input wire logic [`REG_ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic [1:0] channel_request,
	output logic mem_req,
	output logic mem_we,
	output logic [31:0] mem_addr,
	output logic [1:0] mem_size,
	output logic [31:0] mem_wdata,
	input wire logic [31:0] mem_rdata,
	input wire logic mem_ack,
	output logic [1:0] transfer_acknowledge_pin
);

	dma_state_s st_q;
	dma_state_s st_d;

	logic c;
	logic wc;
	logic [15:0] cc;
	logic is16;
	logic single;
	logic dev2mem;
	logic done;
	logic [23:0] dec;
	logic [1:0] nb;
	logic [1:0] go;

	function automatic logic [31:0] unit_bytes(input logic [1:0] sz);
		case (sz)
			`SIZE_BYTE: unit_bytes = `BYTES_BYTE;
			`SIZE_WORD: unit_bytes = `BYTES_WORD;
			`SIZE_LONG: unit_bytes = `BYTES_LONG;
			default: unit_bytes = `BYTES_16B;
		endcase
	endfunction

	// Reserved step code 11 leaves the pointer where it is.
	function automatic logic [31:0] step_ptr(input logic [31:0] p,
			input logic [1:0] mode, input logic [1:0] sz);
		case (mode)
			`STEP_INC: step_ptr = p + unit_bytes(sz);
			`STEP_DEC: step_ptr = p - unit_bytes(sz);
			default: step_ptr = p;
		endcase
	endfunction

	function automatic logic [31:0] beat_addr(input logic [31:0] base,
			input logic [1:0] b);
		beat_addr = base + {28'h000_0000, b, 2'b00};
	endfunction

	always_comb begin
		st_d = st_q;
		st_d.rdata = 32'h0000_0000;
		wc = reg_addr[`CH_SEL_BIT];
		c = st_q.ch;
		cc = st_q.ctl[st_q.ch];
		is16 = cc[`UNIT_SIZE_HI:`UNIT_SIZE_LO] == `SIZE_16B;
		single = cc[`SINGLE_ADDR_BIT];
		dev2mem = cc[`ACK_PHASE_BIT];
		done = 1'b0;
		dec = `CNT_STEP_UNIT;
		nb = st_q.beat + 2'h1;
		go = 2'b00;

		if (reg_wr && reg_addr[1:0] == 2'b00) begin
			case (reg_addr[3:0])
				`OFF_SOURCE: st_d.src[wc] = reg_wdata;
				`OFF_DEST: st_d.dst[wc] = reg_wdata;
				`OFF_COUNT: st_d.cnt[wc] = reg_wdata[23:0];
				`OFF_CONTROL: begin
					st_d.ctl[wc] = reg_wdata[15:0];
					// Writing one keeps the flag, writing zero clears it.
					st_d.ctl[wc][`TRANSFER_END_BIT] =
						st_q.ctl[wc][`TRANSFER_END_BIT] &
						reg_wdata[`TRANSFER_END_BIT];
				end
				default: begin
				end
			endcase
		end

		if (reg_rd && reg_addr[1:0] == 2'b00) begin
			case (reg_addr[3:0])
				`OFF_SOURCE: st_d.rdata = st_q.src[wc];
				`OFF_DEST: st_d.rdata = st_q.dst[wc];
				`OFF_COUNT: st_d.rdata = {8'h00, st_q.cnt[wc]};
				`OFF_CONTROL: st_d.rdata = {16'h0000, st_q.ctl[wc]};
				default: st_d.rdata = 32'h0000_0000;
			endcase
		end

		for (int i = 0; i < 2; i++) begin
			go[i] = channel_request[i] &
				st_q.ctl[i][`CHANNEL_ENABLE_BIT] &
				~st_q.ctl[i][`TRANSFER_END_BIT];
		end

		case (st_q.fsm)
			ST_IDLE: begin
				if (!module_stop && go != 2'b00) begin
					c = ~go[0];
					cc = st_q.ctl[c];
					single = cc[`SINGLE_ADDR_BIT];
					dev2mem = cc[`ACK_PHASE_BIT];
					st_d.ch = c;
					st_d.beat = 2'h0;
					st_d.req = 1'b1;
					// A 16-byte unit runs as longword beats.
					if (cc[`UNIT_SIZE_HI:`UNIT_SIZE_LO] == `SIZE_16B) begin
						st_d.size = `SIZE_LONG;
					end else begin
						st_d.size = cc[`UNIT_SIZE_HI:`UNIT_SIZE_LO];
					end
					if (single && dev2mem) begin
						st_d.fsm = ST_WR;
						st_d.we = 1'b1;
						st_d.addr = st_q.dst[c];
						st_d.ack_act[c] = 1'b1;
					end else begin
						st_d.fsm = ST_RD;
						st_d.we = 1'b0;
						st_d.addr = st_q.src[c];
						st_d.ack_act[c] = ~dev2mem;
					end
				end
			end
			ST_RD: begin
				if (st_q.req && mem_ack) begin
					st_d.hold[st_q.beat] = mem_rdata;
					if (single) begin
						done = 1'b1;
					end else if (is16 && st_q.beat != `LAST_BEAT) begin
						st_d.beat = nb;
						st_d.addr = beat_addr(st_q.src[c], nb);
					end else begin
						st_d.fsm = ST_WR;
						st_d.beat = 2'h0;
						st_d.we = 1'b1;
						st_d.addr = st_q.dst[c];
						st_d.wdata = is16 ? st_q.hold[0] : mem_rdata;
						st_d.ack_act[c] = dev2mem;
					end
				end
			end
			ST_WR: begin
				if (st_q.req && mem_ack) begin
					if (!single && is16 && st_q.beat != `LAST_BEAT) begin
						st_d.beat = nb;
						st_d.addr = beat_addr(st_q.dst[c], nb);
						st_d.wdata = st_q.hold[nb];
					end else begin
						done = 1'b1;
					end
				end
			end
			default: begin
				st_d.fsm = ST_IDLE;
				st_d.req = 1'b0;
				st_d.we = 1'b0;
				st_d.ack_act = 2'b00;
			end
		endcase

		if (done) begin
			st_d.fsm = ST_IDLE;
			st_d.req = 1'b0;
			st_d.we = 1'b0;
			st_d.ack_act = 2'b00;
			if (is16) begin
				st_d.src[c] = st_q.src[c] + `BYTES_16B;
				dec = `CNT_STEP_16B;
			end else if (!(single && dev2mem)) begin
				st_d.src[c] = step_ptr(st_q.src[c],
					cc[`SRC_STEP_HI:`SRC_STEP_LO],
					cc[`UNIT_SIZE_HI:`UNIT_SIZE_LO]);
			end
			if (!(single && !dev2mem)) begin
				st_d.dst[c] = step_ptr(st_q.dst[c],
					cc[`DEST_STEP_HI:`DEST_STEP_LO],
					cc[`UNIT_SIZE_HI:`UNIT_SIZE_LO]);
			end
			// A zero count wraps past zero, which gives 16777216 units, or 4194304 in 16-byte mode.
			if (st_q.cnt[c] != `CNT_ZERO && st_q.cnt[c] <= dec) begin
				st_d.cnt[c] = `CNT_ZERO;
				st_d.ctl[c][`TRANSFER_END_BIT] = 1'b1;
			end else begin
				st_d.cnt[c] = st_q.cnt[c] - dec;
			end
		end

		// Standby clears control and returns the unit to idle; pointers and counts survive.
		if (standby) begin
			st_d.ctl[0] = `CTL_RESET;
			st_d.ctl[1] = `CTL_RESET;
			st_d.fsm = ST_IDLE;
			st_d.req = 1'b0;
			st_d.we = 1'b0;
			st_d.ack_act = 2'b00;
		end

		for (int i = 0; i < 2; i++) begin
			st_d.ack_pin[i] = st_d.ack_act[i] ?
				st_d.ctl[i][`ACK_POLARITY_BIT] :
				~st_d.ctl[i][`ACK_POLARITY_BIT];
		end
	end

	// Pointers and counts take zero at reset, one value of undefined.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			st_q <= '0;
			st_q.fsm <= ST_IDLE;
			st_q.ack_pin <= 2'b11;
		end else begin
			st_q <= st_d;
		end
	end

	assign reg_rdata = st_q.rdata;
	assign mem_req = st_q.req;
	assign mem_we = st_q.we;
	assign mem_addr = st_q.addr;
	assign mem_size = st_q.size;
	assign mem_wdata = st_q.wdata;
	assign transfer_acknowledge_pin = st_q.ack_pin;

endmodule

// *** testbench/dma_channel_props.sv ***
`timescale 1ns/10ps
`include "dma_channel_defs.svh"
module dma_channel_props (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic standby,
	input wire logic module_stop,
	input wire logic [`REG_ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic [1:0] channel_request,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [31:0] mem_addr,
	input wire logic [1:0] mem_size,
	input wire logic [31:0] mem_wdata,
	input wire logic [31:0] mem_rdata,
	input wire logic mem_ack,
	input wire logic [1:0] transfer_acknowledge_pin
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	sequence read_beat;
		mem_req && !mem_we && mem_ack;
	endsequence
	sequence write_beat;
		mem_req && mem_we && mem_ack;
	endsequence
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 0)
		else $error("read data outside its slot");
	a_count_upper: assert property (
		reg_rd && reg_addr[3:0] == 4'h8 |=> reg_rdata[31:24] == 0)
		else $error("count upper bits not zero");
	a_control_upper: assert property (
		reg_rd && reg_addr[3:0] == 4'hC |=> reg_rdata[31:16] == 0)
		else $error("control upper bits not zero");
	a_req_held: assert property (mem_req && !mem_ack && !standby |=>
		mem_req && $stable(mem_addr) && $stable(mem_we))
		else $error("access changed before acknowledge");
	a_stop_holds: assert property (
		(module_stop && !mem_req)[*2] |=> !mem_req)
		else $error("unit started in module standby");
	a_size_legal: assert property (mem_req |-> mem_size != 2'h3)
		else $error("illegal access size");
	a_src_beats: assert property (read_beat ##1 mem_req && !mem_we
		|-> mem_addr == $past(mem_addr) + 32'h0000_0004)
		else $error("read beat address step wrong");
	a_dst_beats: assert property (write_beat ##1 mem_req && mem_we
		|-> mem_addr == $past(mem_addr) + 32'h0000_0004)
		else $error("write beat address step wrong");
	a_standby_abort: assert property (standby |=> !mem_req)
		else $error("access survived standby");
	a_standby_clear: assert property (standby ##1
		(reg_rd && reg_addr[3:0] == 4'hC) |=> reg_rdata == 0)
		else $error("control not cleared by standby");
endmodule
bind dma_channel_address_count_mode dma_channel_props dma_channel_props_inst (
	.clk_sys, .sys_rst, .standby, .module_stop, .reg_addr, .reg_wdata,
	.reg_wr, .reg_rd, .reg_rdata, .channel_request, .mem_req, .mem_we,
	.mem_addr, .mem_size, .mem_wdata, .mem_rdata, .mem_ack,
	.transfer_acknowledge_pin);

// *** testbench/dma_memory_model.sv ***
`timescale 1ns/10ps
module dma_memory_model (
	input wire logic clk_sys,
	input wire logic mem_req,
	input wire logic [31:0] mem_addr,
	input wire logic slow,
	output logic mem_ack,
	output logic [31:0] mem_rdata
);
	logic [1:0] wait_q = 2'h0;
	initial mem_ack = 1'h0;
	initial mem_rdata = 32'h0000_0000;
	// Read data is only valid with the acknowledge; otherwise it toggles.
	always @(posedge clk_sys) begin
		mem_ack <= 1'h0;
		mem_rdata <= ~mem_rdata;
		if (mem_req && !mem_ack) begin
			if (wait_q != 2'h0) begin
				wait_q <= wait_q - 2'h1;
			end else begin
				mem_ack <= 1'h1;
				mem_rdata <= mem_addr ^ 32'hA5A5_0000;
				wait_q <= slow ? 2'h3 : 2'h0;
			end
		end
	end
endmodule

// *** testbench/test_dma_channel_address_count_mode.sv ***
`timescale 1ns/10ps
module test_dma_channel_address_count_mode;
	logic clk_sys = 0, sys_rst = 1, standby = 0, module_stop = 0;
	logic reg_wr = 0, reg_rd = 0, slow = 0, mem_req, mem_we, mem_ack;
	logic [4:0] reg_addr = 0, b = 0;
	logic [31:0] reg_wdata = 0, reg_rdata, mem_addr, mem_wdata, mem_rdata;
	logic [31:0] rd_v, s, d, r, es, ed;
	logic [1:0] channel_request = 0, mem_size, transfer_acknowledge_pin;
	logic [15:0] c;
	logic [15:0] cfg [8] = '{16'h9000, 16'h2400, 16'h5900, 16'hAC00,
		16'hCC00, 16'h5908, 16'h9408, 16'h7000};
	int cnts [8] = '{3, 2, 2, 8, 4, 2, 3, 1};
	int bad_count = 0, comparisons = 0, i, n, u, bs;
	logic [31:0] rd_q [$];
	logic [31:0] ew;
	logic [2:0] es_pin;
	logic act;
	always #25 clk_sys = ~clk_sys;
	dma_channel_address_count_mode dma_channel_address_count_mode_inst (
		.clk_sys, .sys_rst, .standby, .module_stop, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .channel_request, .mem_req, .mem_we,
		.mem_addr, .mem_size, .mem_wdata, .mem_rdata, .mem_ack,
		.transfer_acknowledge_pin);
	dma_memory_model dma_memory_model_inst (.clk_sys, .mem_req, .mem_addr,
		.slow, .mem_ack, .mem_rdata);
	// Dual mode writes must carry the data read earlier in the same unit.
	always @(posedge clk_sys) begin
		if (mem_req && mem_ack && !c[3]) begin
			if (!mem_we) begin
				rd_q.push_back(mem_rdata);
			end else if (rd_q.size() > 0) begin
				ew = rd_q.pop_front();
				comparisons++;
				if (mem_wdata !== ew) begin
					bad_count++;
					$display("[FAIL] mem_wdata exp %h got %h", ew, mem_wdata);
				end
			end
		end
		if (mem_req && mem_ack) begin
			act = c[3] || (mem_we == c[8]);
			es_pin = {act ? c[7] : ~c[7],
				c[11:10] == 2'h3 ? 2'h2 : c[11:10]};
			comparisons++;
			if ({transfer_acknowledge_pin[b[4]], mem_size} !== es_pin) begin
				bad_count++;
				$display("[FAIL] pin_size exp %h got %h", es_pin,
					{transfer_acknowledge_pin[b[4]], mem_size});
			end
		end
	end
	task wr(input logic [4:0] a, input logic [31:0] v);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1;
		@(posedge clk_sys);
		reg_wr <= 0;
	endtask
	task rd(input logic [4:0] a);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1;
		@(posedge clk_sys);
		reg_rd <= 0;
		#1 rd_v = reg_rdata;
	endtask
	task chk(input logic [4:0] a, input logic [31:0] e);
		rd(a);
		comparisons++;
		if (rd_v !== e) begin
			bad_count++;
			$display("[FAIL] reg %h exp %h got %h", a, e, rd_v);
		end
	endtask
	task test_done;
		$display("checks %0d errors %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk_sys);
		bad_count++;
		test_done;
	end
	initial begin
		r = $urandom(32'h0752);
		repeat (16) @(posedge clk_sys);
		sys_rst <= 0;
		repeat (2) begin
			s = $urandom;
			d = $urandom;
			r = $urandom;
			wr(b, s);
			wr(b + 5'h04, d);
			wr(b + 5'h05, ~d);
			wr(b + 5'h08, r);
			wr(b + 5'h0C, {r[31:1], 1'h0} | 32'h0000_0002);
			chk(b, s);
			chk(b + 5'h04, d);
			chk(b + 5'h08, {8'h00, r[23:0]});
			chk(b + 5'h0C, {16'h0000, r[15:2], 2'h0});
			chk(b + 5'h01, 32'h0000_0000);
			b ^= 5'h10;
		end
		for (i = 0; i < 8; i++) begin
			b = i[0] ? 5'h10 : 5'h00;
			r = $urandom;
			c = cfg[i] | {8'h00, r[7:4], 1'h0, r[2], 2'h0};
			slow <= r[8];
			s = $urandom & 32'hFFFF_FFF0;
			d = $urandom;
			wr(b, s);
			wr(b + 5'h04, d);
			wr(b + 5'h08, cnts[i]);
			module_stop <= i == 0;
			wr(b + 5'h0C, {16'h0000, c | 16'h0001});
			channel_request <= i[0] ? 2'h2 : 2'h1;
			if (i == 0) begin
				repeat (20) @(posedge clk_sys);
				chk(b + 5'h08, cnts[i]);
				module_stop <= 0;
			end
			n = 0;
			do begin
				rd(b + 5'h0C);
				n++;
			end while (!rd_v[1] && n < 200);
			channel_request <= 2'h0;
			u = c[11:10] == 3 ? cnts[i] / 4 : cnts[i];
			bs = c[11:10] == 3 ? 16 : 1 << c[11:10];
			es = s;
			ed = d;
			if (!(c[3] && c[8])) begin
				if (c[11:10] == 3 || c[13:12] == 1) es = s + bs * u;
				else if (c[13:12] == 2) es = s - bs * u;
			end
			if (!(c[3] && !c[8])) begin
				if (c[15:14] == 1) ed = d + bs * u;
				else if (c[15:14] == 2) ed = d - bs * u;
			end
			chk(b, es);
			chk(b + 5'h04, ed);
			chk(b + 5'h08, 32'h0000_0000);
			chk(b + 5'h0C, {16'h0000, c | 16'h0003});
			wr(b + 5'h0C, {16'h0000, c | 16'h0002});
			chk(b + 5'h0C, {16'h0000, c | 16'h0002});
			wr(b + 5'h0C, {16'h0000, c});
			chk(b + 5'h0C, {16'h0000, c});
		end
		standby <= 1;
		chk(b + 5'h0C, 32'h0000_0000);
		standby <= 0;
		chk(b, es);
		test_done;
	end
endmodule
